//--- rtl/rpc_link_pkg.sv
// shared constants for the remote procedure link ends
package rpc_link_pkg;
  // ****************************************
  // command codes
  // ****************************************
  localparam logic [1:0] CMD_RPC_TYPE = 2'h2;
  localparam logic [7:0] CMD_DISCOVERY = 8'hBB;
  localparam logic [7:0] CMD_UNIT_NUMBER = 8'hBC;
  localparam logic [7:0] CMD_PROCESS = 8'hBD;
  // ****************************************
  // crc: x^8+x^5+x^4+1, reflected form, lsb first
  // ****************************************
  localparam logic [7:0] CRC_POLY_REFL = 8'h8C;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_EMPTY_REPLY = 8'h00;
  // ****************************************
  // framing timeout in character times, tenths
  // ****************************************
  localparam int TIMEOUT_SETUP_TENTHS = 255;
  localparam int TIMEOUT_OPERATE_TENTHS = 40;
  localparam int CHAR_BITS = 10;
  localparam int CLK_HZ = 125000000;
  localparam int BAUD_SETUP = 115200;
  localparam int BAUD_OPERATE = 2500000;
  // tenth of a character time in clock cycles, rounded down
  localparam int TENTH_CYC_SETUP = CLK_HZ / BAUD_SETUP;
  localparam int TENTH_CYC_OPERATE = CLK_HZ / BAUD_OPERATE;
  localparam int RESP_LEN_DISCOVERY = 6;
  localparam int RESP_LEN_UNIT = 4;
  localparam int MAX_PD_BYTES = 32;

  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ CRC_POLY_REFL;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction
endpackage

//--- rtl/rpc_link_if.sv
// byte stream link between host and remote, one strobe per direction
`timescale 1ns/1ps
interface rpc_link_if;
  logic [7:0] h2r_data;
  logic h2r_valid;
  logic [7:0] r2h_data;
  logic r2h_valid;
  modport host (output h2r_data, output h2r_valid, input r2h_data, input r2h_valid);
  modport remote (input h2r_data, input h2r_valid, output r2h_data, output r2h_valid);
endinterface

//--- rtl/rpc_remote.sv
// remote end: parses special commands, checks crc, builds replies
`timescale 1ns/1ps
module rpc_remote #(
  parameter int PD_BYTES = rpc_link_pkg::MAX_PD_BYTES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  rpc_link_if.remote link,
  input wire logic operate_mode_i,
  input wire logic [7:0] hw_mode_i,
  input wire logic [7:0] sw_mode_i,
  input wire logic [7:0] timeout_tenths_i,
  input wire logic timeout_load_i,
  input wire logic [31:0] unit_number_i,
  input wire logic [7:0] fault_i,
  input wire logic [7:0] in_count_i,
  input wire logic [7:0] out_count_i,
  input wire logic [15:0] process_record_table_pointer_i,
  input wire logic [15:0] mode_record_table_pointer_i,
  input wire logic [PD_BYTES*8-1:0] in_data_i,
  output logic [PD_BYTES*8-1:0] out_data_o,
  output logic out_strobe_o,
  output logic crc_error_o,
  output logic [7:0] mode_snapshot_o
);
  typedef enum {ST_IDLE, ST_RX_DATA, ST_RX_CRC, ST_TX} state_e;
  state_e state_q;
  logic [7:0] cmd_q;
  logic [7:0] crc_q;
  logic [7:0] cnt_q;
  logic [7:0] len_q;
  logic [7:0] timeout_q;
  logic [15:0] tenth_cnt_q;
  logic [7:0] gap_q;
  logic [7:0] tx_crc_q;
  logic [7:0] txd_q;
  logic txv_q;
  logic [PD_BYTES*8-1:0] rxbuf_q;
  logic [7:0] rx_count;
  logic [7:0] tx_len;
  logic [7:0] resp_byte;
  logic [7:0] rx_byte;
  logic gap_expired;
  logic [15:0] tenth_cyc;

  assign rx_byte = link.h2r_data;
  assign link.r2h_data = txd_q;
  assign link.r2h_valid = txv_q;
  // received size counts the fault byte the remote prepends
  assign rx_count = in_count_i + 8'h01;
  assign tenth_cyc = operate_mode_i ? 16'(rpc_link_pkg::TENTH_CYC_OPERATE)
                                    : 16'(rpc_link_pkg::TENTH_CYC_SETUP);

  // ****************************************
  // frame timeout
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      timeout_q <= 8'(rpc_link_pkg::TIMEOUT_SETUP_TENTHS);
    end else if (timeout_load_i) begin
      timeout_q <= timeout_tenths_i;
    end else if (operate_mode_i) begin
      timeout_q <= 8'(rpc_link_pkg::TIMEOUT_OPERATE_TENTHS);
    end else begin
      timeout_q <= 8'(rpc_link_pkg::TIMEOUT_SETUP_TENTHS);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tenth_cnt_q <= 16'h0000;
      gap_q <= 8'h00;
    end else if (link.h2r_valid || state_q == ST_IDLE) begin
      tenth_cnt_q <= 16'h0000;
      gap_q <= 8'h00;
    end else if (tenth_cnt_q >= tenth_cyc - 16'h0001) begin
      tenth_cnt_q <= 16'h0000;
      if (gap_q != 8'hFF) begin
        gap_q <= gap_q + 8'h01;
      end
    end else begin
      tenth_cnt_q <= tenth_cnt_q + 16'h0001;
    end
  end

  // only reception states are aborted; a reply under way finishes
  assign gap_expired = (gap_q > timeout_q) && (state_q == ST_RX_DATA || state_q == ST_RX_CRC);

  // ****************************************
  // reply byte selection
  // ****************************************
  always_comb begin
    resp_byte = 8'h00;
    tx_len = 8'h00;
    case (cmd_q)
      rpc_link_pkg::CMD_DISCOVERY: begin
        tx_len = 8'(rpc_link_pkg::RESP_LEN_DISCOVERY);
        case (cnt_q)
          8'h00: resp_byte = rx_count;
          8'h01: resp_byte = out_count_i;
          8'h02: resp_byte = process_record_table_pointer_i[7:0];
          8'h03: resp_byte = process_record_table_pointer_i[15:8];
          8'h04: resp_byte = mode_record_table_pointer_i[7:0];
          default: resp_byte = mode_record_table_pointer_i[15:8];
        endcase
      end
      rpc_link_pkg::CMD_UNIT_NUMBER: begin
        tx_len = 8'(rpc_link_pkg::RESP_LEN_UNIT);
        resp_byte = unit_number_i[cnt_q[1:0]*8 +: 8];
      end
      rpc_link_pkg::CMD_PROCESS: begin
        tx_len = rx_count;
        if (cnt_q == 8'h00) begin
          resp_byte = fault_i;
        end else begin
          resp_byte = in_data_i[(cnt_q - 8'h01)*8 +: 8];
        end
      end
      default: begin
        tx_len = 8'h00;
        resp_byte = 8'h00;
      end
    endcase
  end

  // ****************************************
  // command parser and responder
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      cmd_q <= 8'h00;
      crc_q <= rpc_link_pkg::CRC_INIT;
      cnt_q <= 8'h00;
      len_q <= 8'h00;
      tx_crc_q <= rpc_link_pkg::CRC_INIT;
      txd_q <= 8'h00;
      txv_q <= 1'b0;
      rxbuf_q <= '0;
      out_data_o <= '0;
      out_strobe_o <= 1'b0;
      crc_error_o <= 1'b0;
      mode_snapshot_o <= 8'h00;
    end else begin
      txv_q <= 1'b0;
      out_strobe_o <= 1'b0;
      crc_error_o <= 1'b0;
      if (gap_expired) begin
        state_q <= ST_IDLE;
      end else begin
        case (state_q)
          ST_IDLE: begin
            if (link.h2r_valid && rx_byte[7:6] == rpc_link_pkg::CMD_RPC_TYPE) begin
              cmd_q <= rx_byte;
              crc_q <= rpc_link_pkg::crc_step(rpc_link_pkg::CRC_INIT, rx_byte);
              cnt_q <= 8'h00;
              mode_snapshot_o <= {sw_mode_i[3:0], hw_mode_i[3:0]};
              if (rx_byte == rpc_link_pkg::CMD_PROCESS && out_count_i != 8'h00) begin
                state_q <= ST_RX_DATA;
              end else begin
                state_q <= ST_RX_CRC;
              end
            end
          end
          ST_RX_DATA: begin
            if (link.h2r_valid) begin
              crc_q <= rpc_link_pkg::crc_step(crc_q, rx_byte);
              rxbuf_q[cnt_q*8 +: 8] <= rx_byte;
              cnt_q <= cnt_q + 8'h01;
              if (cnt_q + 8'h01 == out_count_i) begin
                state_q <= ST_RX_CRC;
              end
            end
          end
          ST_RX_CRC: begin
            if (link.h2r_valid) begin
              cnt_q <= 8'h00;
              if (rx_byte == crc_q) begin
                len_q <= tx_len;
                tx_crc_q <= rpc_link_pkg::CRC_INIT;
                state_q <= ST_TX;
                if (cmd_q == rpc_link_pkg::CMD_PROCESS) begin
                  out_data_o <= rxbuf_q;
                  out_strobe_o <= 1'b1;
                end
              end else begin
                crc_error_o <= 1'b1;
                state_q <= ST_IDLE;
              end
            end
          end
          ST_TX: begin
            txv_q <= 1'b1;
            if (cnt_q < len_q) begin
              txd_q <= resp_byte;
              tx_crc_q <= rpc_link_pkg::crc_step(tx_crc_q, resp_byte);
              cnt_q <= cnt_q + 8'h01;
            end else begin
              // an empty reply sends the zero start value alone
              txd_q <= (len_q == 8'h00) ? rpc_link_pkg::CRC_EMPTY_REPLY : tx_crc_q;
              state_q <= ST_IDLE;
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

//--- rtl/rpc_host.sv
// host end: issues one special command and collects the reply
`timescale 1ns/1ps
module rpc_host #(
  parameter int PD_BYTES = rpc_link_pkg::MAX_PD_BYTES
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  rpc_link_if.host link,
  input wire logic start_i,
  input wire logic [7:0] cmd_i,
  input wire logic [7:0] tx_count_i,
  input wire logic [7:0] rx_count_i,
  input wire logic [PD_BYTES*8-1:0] tx_data_i,
  output logic busy_o,
  output logic done_o,
  output logic crc_ok_o,
  output logic [(PD_BYTES+1)*8-1:0] rx_data_o
);
  typedef enum {ST_IDLE, ST_SEND, ST_WAIT} state_e;
  state_e state_q;
  logic [7:0] cmd_q;
  logic [7:0] txn_q;
  logic [7:0] rxn_q;
  logic [7:0] cnt_q;
  logic [7:0] crc_q;
  logic [7:0] txd_q;
  logic txv_q;
  logic [PD_BYTES*8-1:0] txbuf_q;
  logic [7:0] tx_byte;

  assign link.h2r_data = txd_q;
  assign link.h2r_valid = txv_q;

  always_comb begin
    if (cnt_q == 8'h00) begin
      tx_byte = cmd_q;
    end else if (cnt_q <= txn_q) begin
      tx_byte = txbuf_q[(cnt_q - 8'h01)*8 +: 8];
    end else begin
      tx_byte = crc_q;
    end
  end

  // ****************************************
  // burst send, then collect reply plus crc
  // ****************************************
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      cmd_q <= 8'h00;
      txn_q <= 8'h00;
      rxn_q <= 8'h00;
      cnt_q <= 8'h00;
      crc_q <= rpc_link_pkg::CRC_INIT;
      txd_q <= 8'h00;
      txv_q <= 1'b0;
      txbuf_q <= '0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      crc_ok_o <= 1'b0;
      rx_data_o <= '0;
    end else begin
      txv_q <= 1'b0;
      done_o <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start_i) begin
            cmd_q <= cmd_i;
            txn_q <= (cmd_i == rpc_link_pkg::CMD_PROCESS) ? tx_count_i : 8'h00;
            rxn_q <= rx_count_i;
            txbuf_q <= tx_data_i;
            cnt_q <= 8'h00;
            crc_q <= rpc_link_pkg::CRC_INIT;
            busy_o <= 1'b1;
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          // no gaps between characters of one command
          txv_q <= 1'b1;
          txd_q <= tx_byte;
          if (cnt_q <= txn_q) begin
            crc_q <= rpc_link_pkg::crc_step(crc_q, tx_byte);
            cnt_q <= cnt_q + 8'h01;
          end else begin
            cnt_q <= 8'h00;
            crc_q <= rpc_link_pkg::CRC_INIT;
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (link.r2h_valid) begin
            if (cnt_q < rxn_q) begin
              rx_data_o[cnt_q*8 +: 8] <= link.r2h_data;
              crc_q <= rpc_link_pkg::crc_step(crc_q, link.r2h_data);
              cnt_q <= cnt_q + 8'h01;
            end else begin
              crc_ok_o <= (link.r2h_data == crc_q);
              done_o <= 1'b1;
              busy_o <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

//--- tb/rpc_link_assertions.sv
// link checker for the host/remote byte stream
`timescale 1ns/1ps
module rpc_link_assertions (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] h2r_data,
  input wire logic h2r_valid,
  input wire logic [7:0] r2h_data,
  input wire logic r2h_valid
);
  logic prev_q;
  logic [7:0] cmd_q;
  logic [7:0] rlen_q;
  logic [7:0] rcrc_q;
  logic [7:0] hcrc_q;

  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    end
    return c;
  endfunction

  // command byte is the first of a burst, the host never pauses inside one
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prev_q <= 1'b0;
      cmd_q <= 8'h00;
    end else begin
      prev_q <= h2r_valid;
      if (h2r_valid && !prev_q) begin
        cmd_q <= h2r_data;
      end
    end
  end

  // running crc over a whole burst including its crc byte ends at zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rlen_q <= 8'h00;
      rcrc_q <= 8'h00;
      hcrc_q <= 8'h00;
    end else begin
      rlen_q <= r2h_valid ? rlen_q + 8'h01 : 8'h00;
      rcrc_q <= r2h_valid ? crc(rcrc_q, r2h_data) : 8'h00;
      hcrc_q <= h2r_valid ? crc(hcrc_q, h2r_data) : 8'h00;
    end
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence reply_end;
    r2h_valid ##1 !r2h_valid;
  endsequence

  AST_NO_CROSS: assert property (!(h2r_valid && r2h_valid))
    else $error("both directions active");
  AST_FIRST_RPC: assert property (h2r_valid && !prev_q |-> h2r_data[7:6] == 2'h2)
    else $error("command byte not rpc type");
  AST_REPLY_GAP: assert property ($rose(r2h_valid) |-> $past(h2r_valid, 2) && !$past(h2r_valid))
    else $error("reply not two cycles after crc");
  AST_HOST_CRC: assert property ($fell(h2r_valid) |-> hcrc_q == 8'h00)
    else $error("command crc wrong");
  AST_REPLY_CRC: assert property ($fell(r2h_valid) |-> rcrc_q == 8'h00)
    else $error("reply crc wrong");
  AST_DISC_LEN: assert property ($fell(r2h_valid) && cmd_q == 8'hBB |-> rlen_q == 8'h07)
    else $error("discovery reply length");
  AST_UNIT_LEN: assert property ($fell(r2h_valid) && cmd_q == 8'hBC |-> rlen_q == 8'h05)
    else $error("unit reply length");
  AST_EMPTY_REPLY: assert property ($rose(r2h_valid) && cmd_q[7:6] == 2'h2 && cmd_q < 8'hBB
    |-> r2h_data == 8'h00 ##0 reply_end)
    else $error("empty reply not single zero");
endmodule

//--- tb/test_serial_remote_rpc_responder.sv
// random and corner tests of host and remote joined back to back
`timescale 1ns/1ps
module test_serial_remote_rpc_responder;
  localparam int PD = 5;
  logic clk = 1'b0;
  logic nrst, op_mode, start, strobe_seen, err_seen, crc_ok, done, out_strobe, crc_err2;
  logic busy, crc_err1, err1_seen, tmo_ld;
  logic [7:0] snap, tmo;
  logic [7:0] hw_mode, sw_mode, fault, in_cnt, out_cnt, cmd, txc, rxc;
  logic [15:0] process_record_table_pointer, mode_record_table_pointer;
  logic [31:0] unit, r, q, seed;
  logic [PD*8-1:0] in_data, tx_data, out_data;
  logic [(PD+1)*8-1:0] rx_data;
  int mismatches = 0;
  int compares = 0;
  int n2 = 0;

  rpc_link_if lk();
  rpc_link_if lk2();
  rpc_host #(.PD_BYTES(PD)) u_rpc_host (.clk_i(clk), .nrst_i(nrst), .link(lk),
    .start_i(start), .cmd_i(cmd), .tx_count_i(txc), .rx_count_i(rxc), .tx_data_i(tx_data),
    .busy_o(busy), .done_o(done), .crc_ok_o(crc_ok), .rx_data_o(rx_data));
  rpc_remote #(.PD_BYTES(PD)) u_rpc_remote (.clk_i(clk), .nrst_i(nrst), .link(lk),
    .operate_mode_i(op_mode), .hw_mode_i(hw_mode), .sw_mode_i(sw_mode),
    .timeout_tenths_i(8'h00), .timeout_load_i(1'b0), .unit_number_i(unit), .fault_i(fault),
    .in_count_i(in_cnt), .out_count_i(out_cnt), .process_record_table_pointer_i(process_record_table_pointer), .mode_record_table_pointer_i(mode_record_table_pointer),
    .in_data_i(in_data), .out_data_o(out_data), .out_strobe_o(out_strobe),
    .crc_error_o(crc_err1), .mode_snapshot_o(snap));
  // second remote faces the bench so that gaps and bad crcs can be forced
  rpc_remote #(.PD_BYTES(PD)) u_rpc_remote_fault (.clk_i(clk), .nrst_i(nrst), .link(lk2),
    .operate_mode_i(op_mode), .hw_mode_i(hw_mode), .sw_mode_i(sw_mode),
    .timeout_tenths_i(tmo), .timeout_load_i(tmo_ld), .unit_number_i(unit), .fault_i(fault),
    .in_count_i(in_cnt), .out_count_i(out_cnt), .process_record_table_pointer_i(process_record_table_pointer), .mode_record_table_pointer_i(mode_record_table_pointer),
    .in_data_i(in_data), .out_data_o(), .out_strobe_o(), .crc_error_o(crc_err2),
    .mode_snapshot_o());
  rpc_link_assertions u_rpc_link_assertions (.clk_i(clk), .nrst_i(nrst),
    .h2r_data(lk.h2r_data), .h2r_valid(lk.h2r_valid), .r2h_data(lk.r2h_data),
    .r2h_valid(lk.r2h_valid));

  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (lk2.r2h_valid === 1'b1) n2++;
    if (crc_err2 === 1'b1) err_seen <= 1'b1;
    if (crc_err1 === 1'b1) err1_seen <= 1'b1;
    if (out_strobe === 1'b1) strobe_seen <= 1'b1;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
    end
    return c;
  endfunction
  function automatic logic [63:0] keep(input logic [63:0] v, input logic [7:0] n);
    return v & ~(64'hFFFF_FFFF_FFFF_FFFF << (n * 8));
  endfunction

  task automatic rnd(output logic [31:0] v);
    repeat (32) seed = lfsr(seed);
    v = seed;
  endtask
  task automatic cmp_data(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_data({63'h0, got}, {63'h0, exp});
  endtask
  task automatic conclude();
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic xfer(input logic [7:0] c, input logic [7:0] t, input logic [7:0] n);
    int k;
    @(negedge clk);
    cmd = c;
    txc = t;
    rxc = n;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    cmp_bit(busy, 1'b1);
    k = 0;
    while (done !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    // a missing reply shows up here as done never seen
    cmp_bit(done, 1'b1);
    cmp_bit(busy, 1'b0);
    cmp_bit(crc_ok, 1'b1);
  endtask
  // released data shows the inverse so a stale byte is never mistaken
  task automatic raw(input logic [7:0] b);
    @(negedge clk);
    lk2.h2r_data = b;
    lk2.h2r_valid = 1'b1;
    @(negedge clk);
    lk2.h2r_valid = 1'b0;
    lk2.h2r_data = ~b;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    {nrst, op_mode, start, strobe_seen, err_seen, hw_mode, sw_mode, fault} = '0;
    {err1_seen, tmo_ld, tmo} = '0;
    {in_cnt, out_cnt, cmd, txc, rxc, process_record_table_pointer, mode_record_table_pointer, unit, in_data, tx_data} = '0;
    lk2.h2r_data = 8'h00;
    lk2.h2r_valid = 1'b0;
    seed = 32'hC294;
    repeat (10) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 40; i++) begin
      rnd(r);
      process_record_table_pointer = r[15:0];
      mode_record_table_pointer = r[31:16];
      rnd(unit);
      rnd(r);
      rnd(q);
      {hw_mode, sw_mode, fault} = r[23:0];
      op_mode = r[31];
      in_cnt = (i < 2) ? 8'(i * PD) : 8'(r[26:24] % (PD + 1));
      out_cnt = (i < 2) ? 8'(i * PD) : 8'(r[29:27] % (PD + 1));
      in_data = {q[7:0], unit ^ q};
      tx_data = {q[15:8], ~q};
      xfer(8'hBB, 8'h00, 8'h06);
      cmp_data(keep(rx_data, 6), {16'h0, mode_record_table_pointer, process_record_table_pointer, out_cnt, in_cnt + 8'h01});
      cmp_data({56'h0, snap}, {56'h0, sw_mode[3:0], hw_mode[3:0]});
      xfer(8'hBC, 8'h00, 8'h04);
      cmp_data(keep(rx_data, 4), {32'h0, unit});
      strobe_seen = 1'b0;
      xfer(8'hBD, out_cnt, in_cnt + 8'h01);
      cmp_data(keep(rx_data, in_cnt + 8'h01), keep({in_data, fault}, in_cnt + 8'h01));
      cmp_data(keep(out_data, out_cnt), keep(tx_data, out_cnt));
      cmp_bit(strobe_seen, 1'b1);
      xfer(8'h80 | 8'(q[5:0] % 59), 8'h00, 8'h00);
    end
    op_mode = 1'b1;
    n2 = 0;
    raw(8'hBC);
    repeat (2100) @(negedge clk);
    raw(8'hBB);
    raw(crc8(8'h00, 8'hBB));
    repeat (20) @(negedge clk);
    cmp_data(64'(n2), 64'h7);
    n2 = 0;
    raw(8'hBC);
    repeat (1500) @(negedge clk);
    raw(crc8(8'h00, 8'hBC));
    repeat (20) @(negedge clk);
    cmp_data(64'(n2), 64'h5);
    // a held override of 5 tenths must cut a gap far shorter than 4 characters
    tmo = 8'h05;
    tmo_ld = 1'b1;
    n2 = 0;
    raw(8'hBC);
    repeat (400) @(negedge clk);
    raw(8'hBB);
    raw(crc8(8'h00, 8'hBB));
    repeat (20) @(negedge clk);
    cmp_data(64'(n2), 64'h7);
    tmo_ld = 1'b0;
    n2 = 0;
    err_seen = 1'b0;
    raw(8'hBB);
    raw(crc8(8'h00, 8'hBB) ^ 8'h01);
    repeat (20) @(negedge clk);
    cmp_bit(err_seen, 1'b1);
    cmp_data(64'(n2), 64'h0);
    cmp_bit(err1_seen, 1'b0);
    conclude();
  end
endmodule
